// File: stb_pkg.sv
// Shared constants and state codes for the synchronous bus master
package stb_pkg;
   localparam int STB_DATA_W = 32;
   localparam int STB_ADDR_W = 32;
   localparam int STB_SIZE_W = 2;
   localparam int STB_FC_W = 3;
   localparam int CLK_PERIOD_NS = 50;
   localparam int BUS_CLK_PERIOD_NS = 100;
   localparam int PHASES_PER_BUS_CLK = BUS_CLK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MIN_CYCLE_BUS_CLKS = 2;
   localparam int MIN_CYCLE_PHASES = MIN_CYCLE_BUS_CLKS * PHASES_PER_BUS_CLK;
   localparam int WAIT_PHASES = PHASES_PER_BUS_CLK;
   localparam logic RW_READ = 1'h1;
   localparam logic RW_WRITE = 1'h0;
   localparam logic PIN_ON_N = 1'h0;
   localparam logic PIN_OFF_N = 1'h1;
   localparam logic [1:0] SIZE_LONG_RST = 2'h0;
   localparam logic [2:0] FC_RST = 3'h0;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_S0 = 3'h1,
      ST_S1 = 3'h2,
      ST_S2 = 3'h3,
      ST_W1 = 3'h4,
      ST_W2 = 3'h5,
      ST_S3 = 3'h6
   } stb_state_type;
endpackage

// File: stb_reset_sync.sv
// Reset release synchroniser
`timescale 1ns/1ns
`default_nettype none
module stb_reset_sync (
   input wire logic mclk,
   input wire logic nrst,
   output logic rstSyncN
);
   logic stage1_r;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         stage1_r <= 1'h0;
         rstSyncN <= 1'h0;
      end else begin
         stage1_r <= 1'h1;
         rstSyncN <= stage1_r;
      end
   end
endmodule
`default_nettype wire

// File: stb_bus_arbiter.sv
// Bus request synchroniser and grant logic
`timescale 1ns/1ns
`default_nettype none
module stb_bus_arbiter (
   input wire logic mclk,
   input wire logic rstN,
   input wire logic busRequestN,
   input wire logic busFree,
   output logic busGrantN
);
   logic reqMeta_r;
   logic reqSync_r;
   wire grantNxt = reqSync_r & (busFree | ~busGrantN);

   // Grant is kept while the request stays, taken only when bus is free
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         reqMeta_r <= 1'h0;
         reqSync_r <= 1'h0;
         busGrantN <= 1'h1;
      end else begin
         reqMeta_r <= ~busRequestN;
         reqSync_r <= reqMeta_r;
         busGrantN <= ~grantNxt;
      end
   end
endmodule
`default_nettype wire

// File: stb_bus_master.sv
// Synchronous-termination bus master: read, write, locked sequences
// Functional notes
// - Slave ends cycle with terminate, same sequence
// - Cycle at least two clocks; waits add one
// - Read S0: cycle starts low, address valid, read
// - Read S1: strobes asserted, cycle starts negated
// - Burst request in S1 only when allowed
// - Read S2: buffer enable active
// - Burst acknowledge captured with the terminate
// - Sync inputs sampled directly, no synchroniser
// - No terminate at S2: wait, resample, latch
// - Read S3: strobes negated, address held
// - Write S0: cycle starts low, direction low
// - Write S1: address strobe, buffer enable asserted
// - Write S2: drive all data lines
// - Write data strobe only when the write waits; reads assert it with the address strobe
// - Write S3: strobes off, data held valid
// - Locked sequence indivisible, never bursts
// - Locked flag held; no grant meanwhile
`timescale 1ns/1ns
`default_nettype none
module stb_bus_master
   import stb_pkg::*;
#(
   parameter int DATA_W = STB_DATA_W,
   parameter int ADDR_W = STB_ADDR_W
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [STB_SIZE_W-1:0] reqSize,
   input wire logic [STB_FC_W-1:0] reqFc,
   input wire logic reqCacheInhibit,
   input wire logic reqOperandFirst,
   input wire logic reqLocked,
   input wire logic reqBurstOk,
   input wire logic [DATA_W-1:0] reqData,
   output logic reqAck,
   output logic respValid,
   output logic [DATA_W-1:0] respData,
   output logic respCacheInhibit,
   output logic respBurstAck,
   output logic busClk,
   output logic [ADDR_W-1:0] addrLines,
   output logic [STB_FC_W-1:0] functionCode,
   output logic [STB_SIZE_W-1:0] transferSize,
   output logic readWrite,
   output logic addressStrobeN,
   output logic dataStrobeN,
   output logic externalCycleStartN,
   output logic operandCycleStartN,
   output logic dataBufferEnableN,
   output logic cacheInhibitOutN,
   output logic burstRequestN,
   output logic indivisibleCycleN,
   input wire logic [DATA_W-1:0] dataLinesIn,
   output logic [DATA_W-1:0] dataLinesOut,
   output logic dataLinesOe,
   input wire logic syncTerminateN,
   input wire logic cacheInhibitInN,
   input wire logic burstAcknowledgeN,
   input wire logic busRequestN,
   output logic busGrantN
);
   logic rstN;
   stb_state_type st_r;
   stb_state_type stNxt;
   logic wrOp_r;
   logic firstOp_r;
   logic burstOk_r;
   logic termSeen_r;
   logic inhibitSeen_r;
   logic backSeen_r;

   stb_reset_sync u_rst (
      .mclk(mclk),
      .nrst(nrst),
      .rstSyncN(rstN)
   );

   // Each state is one mclk phase; two phases make one bus clock
   wire canStart = (st_r == ST_IDLE) | (st_r == ST_S3);
   wire start = canStart & reqValid & ~busClk & busGrantN;
   wire endCycle = ((st_r == ST_S2) | (st_r == ST_W2)) & termSeen_r;
   wire sampleEdge = (st_r == ST_S1) | (st_r == ST_W1);
   wire locked = ~indivisibleCycleN;
   wire busFree = (st_r == ST_IDLE) & ~locked & ~start;

   stb_bus_arbiter u_arb (
      .mclk(mclk),
      .rstN(rstN),
      .busRequestN(busRequestN),
      .busFree(busFree),
      .busGrantN(busGrantN)
   );

   always_comb begin
      stNxt = st_r;
      case (st_r)
         ST_IDLE: begin
            stNxt = start ? ST_S0 : ST_IDLE;
         end
         ST_S0: begin
            stNxt = ST_S1;
         end
         ST_S1: begin
            stNxt = ST_S2;
         end
         ST_S2, ST_W2: begin
            // Wait states keep the cycle one bus clock longer each
            stNxt = termSeen_r ? ST_S3 : ST_W1;
         end
         ST_W1: begin
            stNxt = ST_W2;
         end
         ST_S3: begin
            stNxt = start ? ST_S0 : ST_IDLE;
         end
         default: begin
            stNxt = ST_IDLE;
         end
      endcase
   end

   // Pin decode from the next state, so every pin leaves a flip-flop
   wire nWr = start ? reqWrite : wrOp_r;
   wire nFirst = start ? reqOperandFirst : firstOp_r;
   wire nBurst = start ? (reqBurstOk & ~reqWrite & ~reqLocked) : burstOk_r;
   wire nS0 = (stNxt == ST_S0);
   wire nWait = (stNxt == ST_W1) | (stNxt == ST_W2);
   wire nAs = (stNxt == ST_S1) | (stNxt == ST_S2) | nWait;
   wire nLate = (stNxt == ST_S2) | nWait;
   wire nDs = nWr ? nWait : nAs;
   wire nDben = nWr ? (nAs | (stNxt == ST_S3)) : nLate;
   wire nOe = nWr & (nLate | (stNxt == ST_S3));
   wire nBreq = nBurst & ~nWr & nAs;
   wire lockClr = (st_r == ST_IDLE) & ~reqLocked;
   wire nLock = start ? reqLocked : (lockClr ? 1'h0 : locked);

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         st_r <= ST_IDLE;
         busClk <= 1'h0;
         reqAck <= 1'h0;
      end else begin
         st_r <= stNxt;
         busClk <= ~busClk;
         reqAck <= start;
      end
   end

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         addressStrobeN <= PIN_OFF_N;
         dataStrobeN <= PIN_OFF_N;
         externalCycleStartN <= PIN_OFF_N;
         operandCycleStartN <= PIN_OFF_N;
         dataBufferEnableN <= PIN_OFF_N;
         burstRequestN <= PIN_OFF_N;
         indivisibleCycleN <= PIN_OFF_N;
         dataLinesOe <= 1'h0;
      end else begin
         addressStrobeN <= ~nAs;
         dataStrobeN <= ~nDs;
         externalCycleStartN <= ~nS0;
         operandCycleStartN <= ~(nS0 & nFirst);
         dataBufferEnableN <= ~nDben;
         burstRequestN <= ~nBreq;
         indivisibleCycleN <= ~nLock;
         dataLinesOe <= nOe;
      end
   end

   // Address side is only reloaded at a start, so it holds through S3
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         addrLines <= '0;
         functionCode <= FC_RST;
         transferSize <= SIZE_LONG_RST;
         readWrite <= RW_READ;
         cacheInhibitOutN <= PIN_OFF_N;
         dataLinesOut <= '0;
         wrOp_r <= 1'h0;
         firstOp_r <= 1'h0;
         burstOk_r <= 1'h0;
      end else if (start) begin
         addrLines <= reqAddr;
         functionCode <= reqFc;
         transferSize <= reqSize;
         readWrite <= reqWrite ? RW_WRITE : RW_READ;
         cacheInhibitOutN <= ~reqCacheInhibit;
         dataLinesOut <= reqData;
         wrOp_r <= reqWrite;
         firstOp_r <= reqOperandFirst;
         burstOk_r <= nBurst;
      end
   end

   // Sync inputs are stable around rising edges, so no extra stages
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         termSeen_r <= 1'h0;
         inhibitSeen_r <= 1'h0;
         backSeen_r <= 1'h0;
      end else if (sampleEdge) begin
         termSeen_r <= ~syncTerminateN;
         inhibitSeen_r <= ~cacheInhibitInN;
         backSeen_r <= ~burstAcknowledgeN;
      end
   end

   // Bursts are not followed; the acknowledge is only reported
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         respValid <= 1'h0;
         respData <= '0;
         respCacheInhibit <= 1'h0;
         respBurstAck <= 1'h0;
      end else begin
         respValid <= endCycle;
         if (endCycle) begin
            respData <= wrOp_r ? respData : dataLinesIn;
            respCacheInhibit <= inhibitSeen_r;
            respBurstAck <= backSeen_r & burstOk_r;
         end
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstN);

   property p_min_cycle;
      $fell(externalCycleStartN) |-> ##1 (!addressStrobeN) [*2];
   endproperty
   a_min_cycle: assert property (p_min_cycle)
      else $error("Cycle shorter than two bus clocks");

   property p_read_s0;
      (!externalCycleStartN && readWrite) |->
         (dataBufferEnableN && addressStrobeN && !dataLinesOe);
   endproperty
   a_read_s0: assert property (p_read_s0)
      else $error("Read S0 pins wrong");

   property p_read_s1;
      (!externalCycleStartN && readWrite) |=>
         (!addressStrobeN && !dataStrobeN && externalCycleStartN
            && operandCycleStartN);
   endproperty
   a_read_s1: assert property (p_read_s1)
      else $error("Read S1 strobes wrong");

   property p_burst_req;
      !burstRequestN |-> (!addressStrobeN && readWrite && !locked);
   endproperty
   a_burst_req: assert property (p_burst_req)
      else $error("Burst request outside a plain read");

   property p_read_data_buffer_enable;
      (!externalCycleStartN && readWrite) |-> ##2 !dataBufferEnableN;
   endproperty
   a_read_data_buffer_enable: assert property (p_read_data_buffer_enable)
      else $error("Buffer enable not active in read S2");

   property p_term_end;
      respValid |-> $past(termSeen_r) && (st_r == ST_S3);
   endproperty
   a_term_end: assert property (p_term_end)
      else $error("Cycle ended without terminate");

   property p_wait;
      ((st_r == ST_S2 || st_r == ST_W2) && !termSeen_r) |=>
         (st_r == ST_W1) ##1 (st_r == ST_W2);
   endproperty
   a_wait: assert property (p_wait)
      else $error("Wait state not inserted");

   property p_read_s3;
      (respValid && readWrite) |->
         (addressStrobeN && dataStrobeN && dataBufferEnableN
            && $stable(addrLines));
   endproperty
   a_read_s3: assert property (p_read_s3)
      else $error("Read S3 pins wrong");

   property p_write_s0;
      (!externalCycleStartN && !readWrite) |->
         (addressStrobeN && dataStrobeN && !dataLinesOe);
   endproperty
   a_write_s0: assert property (p_write_s0)
      else $error("Write S0 pins wrong");

   property p_req_ack;
      reqAck |-> (!externalCycleStartN && addressStrobeN);
   endproperty
   a_req_ack: assert property (p_req_ack)
      else $error("Request taken without cycle start");

   property p_write_s1;
      (!externalCycleStartN && !readWrite) |=>
         (!addressStrobeN && !dataBufferEnableN && dataStrobeN);
   endproperty
   a_write_s1: assert property (p_write_s1)
      else $error("Write S1 pins wrong");

   property p_write_data;
      (!externalCycleStartN && !readWrite) |-> ##2 dataLinesOe;
   endproperty
   a_write_data: assert property (p_write_data)
      else $error("Write data not driven in S2");

   property p_zero_wait_ds;
      (!externalCycleStartN && !readWrite) ##3 respValid |->
         dataStrobeN && $past(dataStrobeN) && $past(dataStrobeN, 2);
   endproperty
   a_zero_wait_ds: assert property (p_zero_wait_ds)
      else $error("Data strobe in zero-wait write");

   property p_write_s3;
      (respValid && !readWrite) |->
         (dataLinesOe && !dataBufferEnableN && addressStrobeN
            && $stable(dataLinesOut));
   endproperty
   a_write_s3: assert property (p_write_s3)
      else $error("Write S3 hold wrong");

   property p_lock_grant;
      locked |-> busGrantN;
   endproperty
   a_lock_grant: assert property (p_lock_grant)
      else $error("Bus granted during locked sequence");

   property p_idle_quiet;
      (st_r == ST_IDLE) |-> (addressStrobeN && dataStrobeN
         && externalCycleStartN && burstRequestN && !dataLinesOe);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("Pins active while idle");
endmodule
`default_nettype wire

// File: stb_slave_model.sv
// Synchronous 32-bit slave model with selectable wait states
`timescale 1ns/1ns
`default_nettype none
module stb_slave_model (
   input wire logic mclk,
   input wire logic busClk,
   input wire logic addressStrobeN,
   input wire logic readWrite,
   input wire logic [31:0] addrLines,
   input wire logic [31:0] dataLinesOut,
   input wire logic dataLinesOe,
   input wire logic [1:0] waitStates,
   input wire logic inhibitReq,
   input wire logic ackReq,
   output logic syncTerminateN,
   output logic cacheInhibitInN,
   output logic burstAcknowledgeN,
   output logic [31:0] dataLinesIn
);
   logic [31:0] mem [0:15];
   logic [1:0] waitCnt;
   logic drive;
   wire logic [31:0] rdWord = mem[addrLines[5:2]];
   // Released lines show the inverse, never a stale copy
   assign dataLinesIn = drive ? rdWord : ~rdWord;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 32'h0000_0000;
      {syncTerminateN, cacheInhibitInN, burstAcknowledgeN} = 3'h7;
      waitCnt = 2'h0;
      drive = 1'b0;
   end
   // Falling edge keeps the sampled pins clear of rising edges
   always @(negedge mclk) begin
      syncTerminateN <= 1'b1;
      cacheInhibitInN <= 1'b1;
      burstAcknowledgeN <= 1'b1;
      if (addressStrobeN)
         waitCnt <= 2'h0;
      if (!addressStrobeN && !busClk) begin
         if (waitCnt == waitStates) begin
            syncTerminateN <= 1'b0;
            cacheInhibitInN <= ~inhibitReq;
            burstAcknowledgeN <= ~ackReq;
            drive <= readWrite;
         end else
            waitCnt <= waitCnt + 2'h1;
      end
      if (!addressStrobeN && busClk && dataLinesOe)
         mem[addrLines[5:2]] <= dataLinesOut;
      if (addressStrobeN && !busClk)
         drive <= 1'b0;
   end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the synchronous bus master
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import stb_pkg::*;
   logic mclk = 1'b0, nrst = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
   logic [31:0] reqAddr = 32'h0000_0000, reqData = 32'h0000_0000;
   logic [1:0] reqSize = 2'h0, waitStates = 2'h0;
   logic [2:0] reqFc = 3'h5;
   logic reqCacheInhibit = 1'b0, reqOperandFirst = 1'b0, reqLocked = 1'b0;
   logic reqBurstOk = 1'b0, busRequestN = 1'b1;
   logic inhibitReq = 1'b0, ackReq = 1'b0;
   logic reqAck, respValid, respCacheInhibit, respBurstAck, busClk;
   logic [31:0] respData, addrLines, dataLinesIn, dataLinesOut;
   logic [2:0] functionCode;
   logic [1:0] transferSize;
   logic readWrite, addressStrobeN, dataStrobeN, externalCycleStartN;
   logic operandCycleStartN, dataBufferEnableN, cacheInhibitOutN;
   logic burstRequestN, indivisibleCycleN, dataLinesOe, busGrantN;
   logic syncTerminateN, cacheInhibitInN, burstAcknowledgeN;
   int errors = 0, samplesChecked = 0;
   always #25 mclk = ~mclk;
   stb_bus_master dut (.mclk(mclk), .nrst(nrst), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqSize(reqSize),
      .reqFc(reqFc), .reqCacheInhibit(reqCacheInhibit),
      .reqOperandFirst(reqOperandFirst), .reqLocked(reqLocked),
      .reqBurstOk(reqBurstOk), .reqData(reqData), .reqAck(reqAck),
      .respValid(respValid), .respData(respData),
      .respCacheInhibit(respCacheInhibit), .respBurstAck(respBurstAck),
      .busClk(busClk), .addrLines(addrLines), .functionCode(functionCode),
      .transferSize(transferSize), .readWrite(readWrite),
      .addressStrobeN(addressStrobeN), .dataStrobeN(dataStrobeN),
      .externalCycleStartN(externalCycleStartN),
      .operandCycleStartN(operandCycleStartN),
      .dataBufferEnableN(dataBufferEnableN),
      .cacheInhibitOutN(cacheInhibitOutN), .burstRequestN(burstRequestN),
      .indivisibleCycleN(indivisibleCycleN), .dataLinesIn(dataLinesIn),
      .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
      .syncTerminateN(syncTerminateN), .cacheInhibitInN(cacheInhibitInN),
      .burstAcknowledgeN(burstAcknowledgeN), .busRequestN(busRequestN),
      .busGrantN(busGrantN));
   stb_slave_model slave (.mclk(mclk), .busClk(busClk),
      .addressStrobeN(addressStrobeN), .readWrite(readWrite),
      .addrLines(addrLines), .dataLinesOut(dataLinesOut),
      .dataLinesOe(dataLinesOe), .waitStates(waitStates),
      .inhibitReq(inhibitReq), .ackReq(ackReq),
      .syncTerminateN(syncTerminateN),
      .cacheInhibitInN(cacheInhibitInN),
      .burstAcknowledgeN(burstAcknowledgeN), .dataLinesIn(dataLinesIn));
   task automatic chk(input logic ok, input string msg);
      samplesChecked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic print_verdict();
      $display("errors=%0d checks=%0d", errors, samplesChecked);
      if (errors == 0 && samplesChecked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // One bus cycle; d is write data or expected read data
   task automatic busCycle(input logic wr, input logic [31:0] a,
      input logic [31:0] d, input logic [1:0] ws, input logic first,
      input logic bok);
      int n;
      logic dsSeen;
      n = 0;
      dsSeen = 1'b0;
      @(posedge mclk);
      {waitStates, reqWrite, reqAddr, reqData} <= {ws, wr, a, d};
      {reqOperandFirst, reqBurstOk, reqValid} <= {first, bok, 1'b1};
      do begin
         @(posedge mclk);
         #1 n++;
      end while (reqAck !== 1'b1 && n < 20);
      chk(reqAck === 1'b1, "request not taken");
      chk(externalCycleStartN === 1'b0 && operandCycleStartN === ~first &&
         readWrite === ~wr && addrLines === a && addressStrobeN === 1'b1 &&
         functionCode === reqFc && transferSize === reqSize &&
         cacheInhibitOutN === ~reqCacheInhibit && busClk === 1'b1 &&
         dataBufferEnableN === 1'b1, "S0 pins");
      @(posedge mclk);
      reqValid <= 1'b0;
      #1 chk(addressStrobeN === 1'b0 && externalCycleStartN === 1'b1 &&
         operandCycleStartN === 1'b1 && dataBufferEnableN === ~wr &&
         dataStrobeN === wr, "S1 pins");
      chk(burstRequestN === ~(bok & ~wr & ~reqLocked), "burst req");
      @(posedge mclk);
      #1 chk(wr ? dataLinesOe === 1'b1 && dataLinesOut === d
         : dataBufferEnableN === 1'b0, "S2 pins");
      n = 2;
      while (respValid !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1 n++;
         if (wr && dataStrobeN === 1'b0)
            dsSeen = 1'b1;
      end
      chk(n == 3 + 2 * ws, "cycle length");
      chk(dsSeen === (wr && ws != 2'h0), "write strobe");
      chk(addressStrobeN === 1'b1 && dataStrobeN === 1'b1 &&
         addrLines === a && readWrite === ~wr, "S3 pins");
      chk(wr ? dataBufferEnableN === 1'b0 && dataLinesOut === d
         : dataBufferEnableN === 1'b1 && respData === d, "S3 data");
      @(posedge mclk);
      #1 chk(respValid === 1'b0 && dataLinesOe === 1'b0 &&
         dataBufferEnableN === 1'b1, "after S3");
   endtask
   task automatic idleCheck();
      repeat (3) @(posedge mclk);
      #1 chk({addressStrobeN, dataStrobeN, externalCycleStartN,
         operandCycleStartN, burstRequestN, dataLinesOe} === 6'h3e,
         "idle pins");
   endtask
   task automatic plainCycles();
      busCycle(1'b1, 32'h0000_0010, 32'hA5A5_0F0F, 2'h0, 1'b1, 1'b0);
      busCycle(1'b1, 32'h0000_0024, 32'h1234_5678, 2'h1, 1'b0, 1'b0);
      idleCheck();
      busCycle(1'b0, 32'h0000_0010, 32'hA5A5_0F0F, 2'h0, 1'b1, 1'b0);
      busCycle(1'b0, 32'h0000_0024, 32'h1234_5678, 2'h2, 1'b0, 1'b0);
   endtask
   task automatic burstAndInhibit();
      @(posedge mclk);
      {inhibitReq, ackReq} <= 2'h1;
      {reqCacheInhibit, reqSize, reqFc} <= {1'b1, 2'h2, 3'h2};
      busCycle(1'b0, 32'h0000_0010, 32'hA5A5_0F0F, 2'h0, 1'b0, 1'b1);
      chk(respBurstAck === 1'b1 && respCacheInhibit === 1'b0, "ack");
      @(posedge mclk);
      {inhibitReq, ackReq} <= 2'h3;
      {reqCacheInhibit, reqSize, reqFc} <= {1'b0, 2'h0, 3'h5};
      busCycle(1'b0, 32'h0000_0024, 32'h1234_5678, 2'h1, 1'b0, 1'b0);
      chk(respBurstAck === 1'b0 && respCacheInhibit === 1'b1, "inhibit");
      @(posedge mclk);
      {inhibitReq, ackReq} <= 2'h0;
   endtask
   task automatic lockedSeq();
      @(posedge mclk);
      {reqLocked, busRequestN} <= 2'h2;
      busCycle(1'b0, 32'h0000_0010, 32'hA5A5_0F0F, 2'h0, 1'b1, 1'b1);
      busCycle(1'b1, 32'h0000_0010, 32'h0BAD_F00D, 2'h0, 1'b1, 1'b0);
      repeat (4) @(posedge mclk);
      #1 chk(indivisibleCycleN === 1'b0 && busGrantN === 1'b1, "lock");
      @(posedge mclk);
      reqLocked <= 1'b0;
      repeat (6) @(posedge mclk);
      #1 chk(busGrantN === 1'b0, "grant");
      @(posedge mclk);
      busRequestN <= 1'b1;
      repeat (6) @(posedge mclk);
      busCycle(1'b0, 32'h0000_0010, 32'h0BAD_F00D, 2'h0, 1'b1, 1'b0);
   endtask
   initial begin
      #200000 errors++;
      print_verdict();
   end
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      idleCheck();
      plainCycles();
      burstAndInhibit();
      lockedSeq();
      print_verdict();
   end
endmodule
`default_nettype wire
